/* rtl/trig_pkg.sv */
package trig_pkg;
  localparam int NUM_COUNTERS = 4;
  localparam int NUM_THRESH_COUNTERS = 2;
  localparam int NUM_DEBUG_EVENTS = 8;
  localparam int NUM_WATCHPOINTS = 30;
  localparam int WP_LOWER_COUNT = 16;
  localparam int REG_WIDTH = 32;
  localparam int MEAS_WIDTH = 16;

  // register access numbers (supervisor and user alias)
  localparam logic [9:0] TRIG_CTRL_BASE = 10'h110;
  localparam logic [9:0] USER_ALIAS_BASE = 10'h090;
  localparam logic [9:0] REG_INDEX_MASK = 10'h3FC;

  // field positions in 0-is-lsb numbering of the 32-bit word
  localparam int START_CLASS_LSB = 28;
  localparam int STOP_CLASS_LSB = 24;
  localparam int START_SRC_LSB = 19;
  localparam int STOP_SRC_LSB = 14;
  localparam int ARMED_BIT = 13;
  localparam int SCALE_LSB = 8;
  localparam int THRESH_LSB = 0;

  localparam logic [31:0] WRITE_MASK_FULL = 32'h777BE73F;
  localparam logic [31:0] WRITE_MASK_NO_THRESH = 32'h777BE000;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  typedef enum logic [2:0] {
    CLASS_DISABLED = 3'h0,
    CLASS_OVERFLOW = 3'h1,
    CLASS_PROC_EVENT = 3'h2,
    CLASS_HW_SIGNAL = 3'h3,
    CLASS_WP_LOWER = 3'h4,
    CLASS_WP_UPPER = 3'h5
  } trig_class_e;

  localparam logic [3:0] SRC_ZERO = 4'h0;
  localparam logic [3:0] SRC_OVF_MAX = 4'h3;
  localparam logic [3:0] SRC_DEBUG_MAX = 4'h7;
  localparam logic [3:0] SRC_QUAL_EDGE = 4'h8;
  localparam logic [3:0] SRC_WP_UPPER_MAX = 4'hD;
endpackage

/* rtl/trig_select.sv */
`timescale 1ns/1ps
module trig_select
  import trig_pkg::*;
#(
  parameter int COUNTER_ID = 0
) (
  input  wire logic [2:0]                   class_i,
  input  wire logic [3:0]                   source_i,
  input  wire logic                         is_stop_i,
  input  wire logic [NUM_COUNTERS-1:0]      ovf_rise_i,
  input  wire logic                         irq_event_i,
  input  wire logic [NUM_DEBUG_EVENTS-1:0]  debug_event_i,
  input  wire logic                         qual_rise_i,
  input  wire logic                         qual_fall_i,
  input  wire logic [NUM_WATCHPOINTS-1:0]   watchpoint_i,
  output logic                              enabled_o,
  output logic                              event_o
);
  always_comb begin
    enabled_o = 1'b0;
    event_o   = 1'b0;
    unique case (class_i)
      CLASS_DISABLED: begin
        enabled_o = 1'b0;
      end
      CLASS_OVERFLOW: begin
        enabled_o = 1'b1;
        if (source_i <= SRC_OVF_MAX && source_i[1:0] != 2'(COUNTER_ID)) begin
          event_o = ovf_rise_i[source_i[1:0]];
        end
      end
      CLASS_PROC_EVENT: begin
        enabled_o = 1'b1;
        event_o   = (source_i == SRC_ZERO) && irq_event_i;
      end
      CLASS_HW_SIGNAL: begin
        enabled_o = 1'b1;
        if (source_i <= SRC_DEBUG_MAX) begin
          event_o = debug_event_i[source_i[2:0]];
        end else if (source_i == SRC_QUAL_EDGE) begin
          event_o = is_stop_i ? qual_fall_i : qual_rise_i;
        end
      end
      CLASS_WP_LOWER: begin
        enabled_o = 1'b1;
        event_o   = watchpoint_i[source_i];
      end
      CLASS_WP_UPPER: begin
        enabled_o = 1'b1;
        if (source_i <= SRC_WP_UPPER_MAX) begin
          event_o = watchpoint_i[WP_LOWER_COUNT + int'(source_i)];
        end
      end
      default: begin
        enabled_o = 1'b1;
        event_o   = 1'b0;
      end
    endcase
  end
endmodule

/* rtl/thresh_qual.sv */
`timescale 1ns/1ps
module thresh_qual
  import trig_pkg::*;
(
  input  wire logic [5:0]            threshold_i,
  input  wire logic [2:0]            scale_i,
  input  wire logic [MEAS_WIDTH-1:0] measured_i,
  output logic                       pass_o
);
  logic [MEAS_WIDTH-1:0] limit;
  always_comb begin
    limit  = MEAS_WIDTH'({7'h00, threshold_i} << scale_i);
    pass_o = measured_i > limit;
  end
endmodule

/* rtl/perf_counter_trigger_threshold.sv */
`timescale 1ns/1ps
module perf_counter_trigger_threshold
  import trig_pkg::*;
#(
  parameter int N_CNT = NUM_COUNTERS
) (
  input  wire logic                               mclk_i,
  input  wire logic                               rst_i,
  input  wire logic                               reg_wr_i,
  input  wire logic                               reg_rd_i,
  input  wire logic [9:0]                         reg_num_i,
  input  wire logic [REG_WIDTH-1:0]               reg_wdata_i,
  output logic [REG_WIDTH-1:0]                    reg_rdata_o,
  output logic                                    reg_hit_o,
  input  wire logic                               freeze_all_counters_i,
  input  wire logic [N_CNT-1:0]                   freeze_this_counter_i,
  input  wire logic [N_CNT-1:0]                   local_count_ok_i,
  input  wire logic [N_CNT-1:0]                   counter_msb_i,
  input  wire logic                               irq_taken_i,
  input  wire logic [NUM_DEBUG_EVENTS-1:0]        debug_event_i,
  input  wire logic                               counter_qual_i,
  input  wire logic [NUM_WATCHPOINTS-1:0]         watchpoint_i,
  input  wire logic [NUM_THRESH_COUNTERS-1:0]     thresh_event_i,
  input  wire logic [MEAS_WIDTH-1:0]              thresh_measure_i,
  input  wire logic [N_CNT-1:0]                   event_i,
  output logic [N_CNT-1:0]                        count_enable_o,
  output logic [N_CNT-1:0]                        armed_o
);
  typedef struct packed {
    logic [N_CNT-1:0][REG_WIDTH-1:0] ctrl;
    logic [N_CNT-1:0]                ovf_prev;
    logic [1:0]                      qual_sync;
    logic                            qual_prev;
    logic [REG_WIDTH-1:0]            rdata;
    logic [N_CNT-1:0]                count_en;
  } state_s;

  state_s st;
  state_s next_st;

  logic [N_CNT-1:0] ovf_rise;
  logic             qual_rise;
  logic             qual_fall;
  logic [N_CNT-1:0] start_en;
  logic [N_CNT-1:0] start_ev;
  logic [N_CNT-1:0] stop_en;
  logic [N_CNT-1:0] stop_ev;
  logic [N_CNT-1:0] thresh_ok;

  function automatic logic [2:0] reg_index(input logic [9:0] num);
    return 3'(num[1:0]);
  endfunction

  function automatic logic reg_match(input logic [9:0] num, input logic [9:0] base);
    return (num & REG_INDEX_MASK) == base;
  endfunction

  assign ovf_rise  = counter_msb_i & ~st.ovf_prev;
  assign qual_rise = st.qual_sync[1] & ~st.qual_prev;
  assign qual_fall = ~st.qual_sync[1] & st.qual_prev;

  genvar g;
  generate
    for (g = 0; g < N_CNT; g++) begin : g_cnt
      logic [2:0] start_cls;
      logic [2:0] stop_cls;
      logic [3:0] start_src;
      logic [3:0] stop_src;
      logic       stop_en_raw;
      assign start_cls = st.ctrl[g][START_CLASS_LSB +: 3];
      assign stop_cls  = st.ctrl[g][STOP_CLASS_LSB +: 3];
      assign start_src = st.ctrl[g][START_SRC_LSB +: 4];
      assign stop_src  = st.ctrl[g][STOP_SRC_LSB +: 4];

      trig_select #(
        .COUNTER_ID (g)
      ) u_start (
        .class_i       (start_cls),
        .source_i      (start_src),
        .is_stop_i     (1'b0),
        .ovf_rise_i    (ovf_rise),
        .irq_event_i   (irq_taken_i),
        .debug_event_i (debug_event_i),
        .qual_rise_i   (qual_rise),
        .qual_fall_i   (qual_fall),
        .watchpoint_i  (watchpoint_i),
        .enabled_o     (start_en[g]),
        .event_o       (start_ev[g])
      );

      trig_select #(
        .COUNTER_ID (g)
      ) u_stop (
        .class_i       (stop_cls),
        .source_i      (stop_src),
        .is_stop_i     (1'b1),
        .ovf_rise_i    (ovf_rise),
        .irq_event_i   (irq_taken_i),
        .debug_event_i (debug_event_i),
        .qual_rise_i   (qual_rise),
        .qual_fall_i   (qual_fall),
        .watchpoint_i  (watchpoint_i),
        .enabled_o     (stop_en_raw),
        .event_o       (stop_ev[g])
      );
      // disabled stop class with nonzero source is reserved, treated as enabled without events
      assign stop_en[g] = stop_en_raw | (stop_src != SRC_ZERO);

      if (g < NUM_THRESH_COUNTERS) begin : g_th
        logic pass;
        thresh_qual u_th (
          .threshold_i (st.ctrl[g][THRESH_LSB +: 6]),
          .scale_i     (st.ctrl[g][SCALE_LSB +: 3]),
          .measured_i  (thresh_measure_i),
          .pass_o      (pass)
        );
        assign thresh_ok[g] = ~thresh_event_i[g] | pass;
      end else begin : g_nth
        assign thresh_ok[g] = 1'b1;
      end
    end
  endgenerate

  always_comb begin
    logic       frozen;
    logic       armed;
    logic       sw_hit;
    logic [2:0] idx;
    logic       start_on;
    next_st = st;
    frozen  = 1'b0;
    armed   = 1'b0;
    sw_hit  = 1'b0;
    idx     = reg_index(reg_num_i);
    start_on = 1'b0;
    next_st.ovf_prev  = counter_msb_i;
    next_st.qual_sync = {st.qual_sync[0], counter_qual_i};
    next_st.qual_prev = st.qual_sync[1];
    sw_hit = reg_wr_i && reg_match(reg_num_i, TRIG_CTRL_BASE);
    for (int i = 0; i < N_CNT; i++) begin
      frozen   = freeze_all_counters_i | freeze_this_counter_i[i];
      armed    = st.ctrl[i][ARMED_BIT];
      start_on = start_en[i] && st.ctrl[i][START_CLASS_LSB +: 3] != 3'(CLASS_DISABLED);
      if (sw_hit && idx == 3'(i)) begin
        next_st.ctrl[i] = reg_wdata_i & ((i < NUM_THRESH_COUNTERS) ? WRITE_MASK_FULL
                                                                   : WRITE_MASK_NO_THRESH);
      end else if (!frozen) begin
        if (start_on && !armed && start_ev[i]) begin
          next_st.ctrl[i][ARMED_BIT] = 1'b1;
        end else if (stop_en[i] && armed && stop_ev[i]) begin
          next_st.ctrl[i][ARMED_BIT] = 1'b0;
        end
      end
      // counting qualification, freeze bits never written here
      next_st.count_en[i] = event_i[i] && !freeze_all_counters_i && !freeze_this_counter_i[i]
                            && local_count_ok_i[i] && thresh_ok[i]
                            && (!(start_on || stop_en[i]) || armed);
    end
    next_st.rdata = '0;
    if (reg_rd_i && (reg_match(reg_num_i, TRIG_CTRL_BASE) || reg_match(reg_num_i, USER_ALIAS_BASE))) begin
      next_st.rdata = st.ctrl[idx[1:0]];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_hit_o      = (reg_rd_i || reg_wr_i) && reg_match(reg_num_i, TRIG_CTRL_BASE)
                          || reg_rd_i && reg_match(reg_num_i, USER_ALIAS_BASE);
  assign reg_rdata_o    = st.rdata;
  assign count_enable_o = st.count_en;
  generate
    for (g = 0; g < N_CNT; g++) begin : g_arm
      assign armed_o[g] = st.ctrl[g][ARMED_BIT];
    end
  endgenerate
endmodule

/* verif/trig_chk.sv */
`timescale 1ns/1ps
module trig_chk
  import trig_pkg::*;
#(
  parameter int N_CNT = NUM_COUNTERS
) (
  input wire logic             mclk_i,
  input wire logic             rst_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [9:0]       reg_num_i,
  input wire logic [31:0]      reg_wdata_i,
  input wire logic [31:0]      reg_rdata_o,
  input wire logic             reg_hit_o,
  input wire logic             freeze_all_counters_i,
  input wire logic [N_CNT-1:0] freeze_this_counter_i,
  input wire logic [N_CNT-1:0] local_count_ok_i,
  input wire logic [N_CNT-1:0] event_i,
  input wire logic [N_CNT-1:0] count_enable_o,
  input wire logic [N_CNT-1:0] armed_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr0;
    reg_wr_i && reg_num_i == TRIG_CTRL_BASE;
  endsequence
  sequence s_wr_alias;
    reg_wr_i && (reg_num_i & REG_INDEX_MASK) == USER_ALIAS_BASE;
  endsequence
  sequence s_rd_alias;
    reg_rd_i && (reg_num_i & REG_INDEX_MASK) == USER_ALIAS_BASE;
  endsequence
  a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == '0)
    else $error("read data not zero outside a read");
  a_alias_wr_refused: assert property (s_wr_alias |-> !reg_hit_o)
    else $error("write to alias accepted");
  a_alias_rd_hit: assert property (s_rd_alias |-> reg_hit_o)
    else $error("alias read not decoded");
  a_ctrl_wr_hit: assert property (reg_wr_i && (reg_num_i & REG_INDEX_MASK) == TRIG_CTRL_BASE |-> reg_hit_o)
    else $error("control write not decoded");
  a_sw_arm_wins: assert property (s_wr0 |=> armed_o[0] == $past(reg_wdata_i[ARMED_BIT]))
    else $error("armed flag not written by software");
  a_freeze_all_count: assert property (freeze_all_counters_i |=> count_enable_o == '0)
    else $error("counting while all frozen");
  a_freeze_own_count: assert property ((count_enable_o & $past(freeze_this_counter_i)) == '0)
    else $error("counting while counter frozen");
  a_event_gate_ok: assert property ((count_enable_o & ~$past(event_i & local_count_ok_i)) == '0)
    else $error("count without qualified event");
  a_frozen_armed_hold: assert property (freeze_all_counters_i && !reg_wr_i |=> $stable(armed_o))
    else $error("trigger taken while frozen");
endmodule
bind perf_counter_trigger_threshold trig_chk #(.N_CNT(N_CNT)) i_trig_chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_num_i(reg_num_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .freeze_all_counters_i(freeze_all_counters_i),
  .freeze_this_counter_i(freeze_this_counter_i), .local_count_ok_i(local_count_ok_i), .event_i(event_i),
  .count_enable_o(count_enable_o), .armed_o(armed_o));

/* verif/ev_src.sv */
`timescale 1ns/1ps
module ev_src
  import trig_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  input  wire logic [2:0]                 kind_i,
  input  wire logic [4:0]                 idx_i,
  output logic [NUM_WATCHPOINTS-1:0]      watchpoint_o,
  output logic [NUM_DEBUG_EVENTS-1:0]     debug_event_o,
  output logic                            irq_taken_o,
  output logic [NUM_COUNTERS-1:0]         counter_msb_o,
  output logic                            counter_qual_o
);
  // one-cycle event pulses; qualifier holds its level
  always_ff @(posedge mclk_i) begin
    watchpoint_o   <= (kind_i == 3'h1) ? 30'h00000001 << idx_i : 30'h00000000;
    debug_event_o  <= (kind_i == 3'h2) ? 8'h01 << idx_i[2:0] : 8'h00;
    irq_taken_o    <= kind_i == 3'h3;
    counter_msb_o  <= (kind_i == 3'h4) ? 4'h1 << idx_i[1:0] : 4'h0;
    counter_qual_o <= rst_i ? 1'b0 : (kind_i == 3'h5) ? 1'b1 : (kind_i == 3'h6) ? 1'b0 : counter_qual_o;
  end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top
  import trig_pkg::*;
;
  localparam logic [31:0] ARM_SET = 32'h00002000;
  logic        mclk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, freeze_all = 1'b0;
  logic [9:0]  reg_num = 10'h000;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic        hit, irq, qual;
  logic [3:0]  frz = 4'h0, ok = 4'hF, ev = 4'h0, msb, cen, armed;
  logic [7:0]  dbg;
  logic [29:0] wp;
  logic [1:0]  tev = 2'h0;
  logic [15:0] meas = 16'h0000;
  logic [2:0]  kind = 3'h0;
  logic [4:0]  idx = 5'h00;
  int          err_count = 0, num_checks = 0;
  initial forever #4 mclk_i = ~mclk_i;
  perf_counter_trigger_threshold i_perf_counter_trigger_threshold (.mclk_i(mclk_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_num_i(reg_num), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_hit_o(hit), .freeze_all_counters_i(freeze_all), .freeze_this_counter_i(frz), .local_count_ok_i(ok),
    .counter_msb_i(msb), .irq_taken_i(irq), .debug_event_i(dbg), .counter_qual_i(qual), .watchpoint_i(wp),
    .thresh_event_i(tev), .thresh_measure_i(meas), .event_i(ev), .count_enable_o(cen), .armed_o(armed));
  ev_src i_ev_src (.mclk_i(mclk_i), .rst_i(rst_i), .kind_i(kind), .idx_i(idx), .watchpoint_o(wp),
    .debug_event_o(dbg), .irq_taken_o(irq), .counter_msb_o(msb), .counter_qual_o(qual));
  function automatic logic [31:0] cw(input logic [2:0] a, input logic [3:0] b, input logic [2:0] c,
                                     input logic [3:0] d);
    return (32'(a) << START_CLASS_LSB) | (32'(b) << START_SRC_LSB) | (32'(c) << STOP_CLASS_LSB)
         | (32'(d) << STOP_SRC_LSB);
  endfunction
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [9:0] n, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_num  <= n;
    wdata    <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] n, input logic [31:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_num  <= n;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // program, fire one source event, then look at the armed flag
  task automatic trig(input int c, input logic [31:0] w, input logic [2:0] k, input logic [4:0] i,
                      input logic e, input logic [1:0] f);
    {freeze_all, frz[c]} <= f;
    wr(TRIG_CTRL_BASE + 10'(c), w);
    @(posedge mclk_i);
    kind <= k;
    idx  <= i;
    @(posedge mclk_i);
    kind <= 3'h0;
    repeat (6) @(posedge mclk_i);
    #1;
    `CHK(armed[c], e)
    {freeze_all, frz[c]} <= 2'h0;
  endtask
  task automatic cnt(input logic [15:0] m, input logic e);
    meas <= m;
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK(cen[0], e)
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rd(TRIG_CTRL_BASE + 10'(i), CTRL_RESET);
    wr(TRIG_CTRL_BASE, 32'hFFFFFFFF);
    rd(TRIG_CTRL_BASE, WRITE_MASK_FULL);
    wr(TRIG_CTRL_BASE + 10'h002, 32'hFFFFFFFF);
    rd(TRIG_CTRL_BASE + 10'h002, WRITE_MASK_NO_THRESH);
    wr(USER_ALIAS_BASE, 32'h00000000);
    rd(USER_ALIAS_BASE, WRITE_MASK_FULL);
    rd(USER_ALIAS_BASE + 10'h002, WRITE_MASK_NO_THRESH);
    rd(10'h200, 32'h00000000);
    trig(0, cw(1, 1, 0, 0), 4, 1, 1, 0);
    trig(0, cw(0, 0, 1, 2) | ARM_SET, 4, 2, 0, 0);
    trig(1, cw(1, 1, 0, 0), 4, 1, 0, 0);
    trig(1, cw(1, 4, 0, 0), 4, 0, 0, 0);
    trig(2, cw(2, 0, 1, 3), 3, 0, 1, 0);
    trig(2, cw(1, 3, 2, 0) | ARM_SET, 3, 0, 0, 0);
    trig(3, cw(3, 7, 0, 0), 2, 7, 1, 0);
    trig(3, cw(0, 0, 3, 5) | ARM_SET, 2, 5, 0, 0);
    trig(0, cw(3, 8, 0, 0), 5, 0, 1, 0);
    trig(0, cw(0, 0, 3, 8) | ARM_SET, 6, 0, 0, 0);
    trig(1, cw(4, 15, 0, 0), 1, 15, 1, 0);
    trig(1, cw(0, 0, 4, 3) | ARM_SET, 1, 3, 0, 0);
    trig(2, cw(5, 13, 0, 0), 1, 29, 1, 0);
    trig(2, cw(0, 0, 5, 1) | ARM_SET, 1, 17, 0, 0);
    trig(2, cw(5, 14, 0, 0), 1, 29, 0, 0);
    trig(3, cw(6, 1, 0, 0), 1, 1, 0, 0);
    trig(3, cw(4, 5, 0, 0), 1, 5, 0, 2);
    trig(3, cw(4, 5, 0, 0), 1, 5, 0, 1);
    trig(3, cw(4, 5, 0, 0), 1, 5, 1, 0);
    ev <= 4'h1;
    wr(TRIG_CTRL_BASE, cw(1, 3, 0, 0));
    cnt(16'h0000, 1'b0);
    wr(TRIG_CTRL_BASE, cw(1, 3, 0, 0) | ARM_SET);
    cnt(16'h0000, 1'b1);
    wr(TRIG_CTRL_BASE, 32'h00000203);
    cnt(16'h0000, 1'b1);
    tev <= 2'h1;
    cnt(16'h000C, 1'b0);
    cnt(16'h000D, 1'b1);
    report_and_stop();
  end
endmodule
